/* exec_pkg.sv */
package exec_pkg;

  // ==========================================================================
  // Widths and depths.
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int NIBBLE_W = 4;

  // ==========================================================================
  // Field positions.
  localparam int MSB = 7;
  localparam int LSB = 0;

  // ==========================================================================
  // Reset values and constants.
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;
  localparam logic GIE_RESET = 1'b0;

  // ==========================================================================
  // Operations handled by the block.
  typedef enum logic [4:0] {
    no_op,
    subroutine_return_op,
    return_with_immediate_op,
    interrupt_return_op,
    rotate_left_mem_op,
    rotate_left_to_acc_op,
    rotate_left_carry_mem_op,
    rotate_left_carry_to_acc_op,
    rotate_right_mem_op,
    rotate_right_to_acc_op,
    rotate_right_carry_mem_op,
    rotate_right_carry_to_acc_op,
    subtract_borrow_to_acc_op,
    subtract_borrow_to_mem_op,
    decrement_skip_zero_op,
    decrement_skip_zero_to_acc_op
  } op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_return,
    st_dummy
  } exec_state_t;

endpackage

/* exec_properties.sv */
`timescale 1ns/1ps

// ============================================================================
// Checks on the execution block, seen from its ports.
module exec_properties (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_op_valid,
  input wire exec_pkg::op_t i_op,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] i_acc,
  input wire logic i_carry,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_skip,
  input wire logic o_pc_load,
  input wire logic o_acc_we,
  input wire logic [7:0] o_acc_wdata,
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_carry_we,
  input wire logic o_carry,
  input wire logic o_arith_flags_we,
  input wire logic o_global_interrupt_enable,
  input wire logic [2:0] o_stack_pointer
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic take;
  logic is_ret;
  logic is_dec;
  assign take = i_op_valid && !o_busy;
  assign is_ret = i_op inside {exec_pkg::subroutine_return_op,
    exec_pkg::return_with_immediate_op, exec_pkg::interrupt_return_op};
  assign is_dec = i_op inside {exec_pkg::decrement_skip_zero_op,
    exec_pkg::decrement_skip_zero_to_acc_op};
  sequence ret_seq;
    o_busy && !o_done ##1 o_pc_load && o_done && !o_busy;
  endsequence
  sequence skip_seq;
    o_skip && o_busy ##1 o_done && !o_busy && !o_skip;
  endsequence
  chk_rotl_mem: assert property (
    take && i_op == exec_pkg::rotate_left_mem_op |=> o_mem_we && !o_acc_we
    && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])})
    else $error("rotate left to memory wrong");
  chk_rotr_acc: assert property (
    take && i_op == exec_pkg::rotate_right_to_acc_op |=> o_acc_we && !o_mem_we
    && o_acc_wdata == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])})
    else $error("rotate right to accumulator wrong");
  chk_rlc_mem: assert property (
    take && i_op == exec_pkg::rotate_left_carry_mem_op |=> o_carry_we
    && o_carry == $past(i_mem_rdata[7])
    && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_carry)})
    else $error("rotate left through carry wrong");
  chk_rrc_acc: assert property (
    take && i_op == exec_pkg::rotate_right_carry_to_acc_op |=> o_carry_we
    && !o_mem_we && o_carry == $past(i_mem_rdata[0])
    && o_acc_wdata == {$past(i_carry), $past(i_mem_rdata[7:1])})
    else $error("rotate right through carry wrong");
  chk_sbc_acc: assert property (
    take && i_op == exec_pkg::subtract_borrow_to_acc_op |=> o_acc_we
    && o_arith_flags_we && o_acc_wdata == $past(i_acc) + ~$past(i_mem_rdata) + $past(i_carry))
    else $error("subtract with borrow wrong");
  chk_ret_seq: assert property (
    take && is_ret |=> ret_seq)
    else $error("return sequence wrong");
  chk_ret_pop: assert property (
    take && is_ret |=> o_stack_pointer == $past(o_stack_pointer) - 3'h1)
    else $error("return did not pop");
  chk_ret_imm: assert property (
    take && i_op == exec_pkg::return_with_immediate_op |=> ##1 o_acc_we
    && o_acc_wdata == $past(i_imm, 2))
    else $error("return immediate wrong");
  chk_interrupt_return_op_gie: assert property (
    take && i_op == exec_pkg::interrupt_return_op |=> ##1 o_global_interrupt_enable)
    else $error("interrupt enable not set");
  chk_skip_zero: assert property (
    take && is_dec && i_mem_rdata == 8'h01 |=> skip_seq)
    else $error("zero decrement did not skip");
  chk_dec_noskip: assert property (
    take && i_op == exec_pkg::decrement_skip_zero_op && i_mem_rdata != 8'h01
    |=> o_done && !o_skip && !o_busy && o_mem_wdata == $past(i_mem_rdata) - 8'h01)
    else $error("nonzero decrement wrong");
endmodule

/* return_rotate_skip_exec.sv */
`timescale 1ns/1ps

// Operation
// - Subroutine return reloads the program counter from the stack top and pops it.
// - Return with immediate reloads the program counter and loads the accumulator.
// - Interrupt return reloads the program counter and sets global interrupt enable.
// - Rotate left memory: bits move up one, bit 7 to bit 0, written back.
// - Rotate left to accumulator: same rotation into accumulator, memory untouched.
// - Rotate left through carry memory: carry into bit 0, bit 7 into carry.
// - Rotate left through carry to accumulator, carry updated, memory untouched.
// - Rotate right memory: bits move down one, bit 0 to bit 7, written back.
// - Rotate right to accumulator: same rotation into accumulator, memory untouched.
// - Rotate right through carry memory: carry into bit 7, bit 0 into carry.
// - Subtract with borrow sets all four flags, result to accumulator or memory.
// - Decrement memory and skip on zero with one dummy cycle, else one cycle.

module return_rotate_skip_exec (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_op_valid,
  input wire exec_pkg::op_t i_op,
  input wire logic [exec_pkg::DATA_W-1:0] i_imm,
  input wire logic [exec_pkg::DATA_W-1:0] i_mem_rdata,
  input wire logic [exec_pkg::DATA_W-1:0] i_acc,
  input wire logic i_carry,
  input wire logic i_push,
  input wire logic [exec_pkg::PC_W-1:0] i_push_pc,
  input wire logic i_interrupt_taken,
  output logic o_busy,
  output logic o_done,
  output logic o_skip,
  output logic o_pc_load,
  output logic [exec_pkg::PC_W-1:0] o_pc,
  output logic o_acc_we,
  output logic [exec_pkg::DATA_W-1:0] o_acc_wdata,
  output logic o_mem_we,
  output logic [exec_pkg::DATA_W-1:0] o_mem_wdata,
  output logic o_carry_we,
  output logic o_carry,
  output logic o_arith_flags_we,
  output logic o_overflow,
  output logic o_zero,
  output logic o_aux_carry,
  output logic o_global_interrupt_enable,
  output logic [exec_pkg::SP_W-1:0] o_stack_pointer
);

  typedef struct packed {
    exec_pkg::exec_state_t state;
    exec_pkg::op_t pend_op;
    logic [exec_pkg::DATA_W-1:0] imm;
    logic [exec_pkg::SP_W-1:0] sp;
    logic [exec_pkg::PC_W-1:0] pc;
    logic pc_load;
    logic [exec_pkg::DATA_W-1:0] acc;
    logic acc_we;
    logic [exec_pkg::DATA_W-1:0] mem_wdata;
    logic mem_we;
    logic carry;
    logic carry_we;
    logic overflow;
    logic zero;
    logic aux_carry;
    logic arith_we;
    logic gie;
    logic skip;
    logic done;
  } exec_reg_t;

  exec_reg_t r;
  exec_reg_t next_r;
  stack_if stk ();

  logic [exec_pkg::DATA_W-1:0] rot_left;
  logic [exec_pkg::DATA_W-1:0] rot_left_carry;
  logic [exec_pkg::DATA_W-1:0] rot_right;
  logic [exec_pkg::DATA_W-1:0] rot_right_carry;
  logic [exec_pkg::DATA_W-1:0] decremented;
  logic [exec_pkg::DATA_W:0] difference;
  logic [exec_pkg::NIBBLE_W:0] low_difference;
  logic sub_overflow;
  logic return_issue;
  logic push_taken;

  // ==========================================================================
  // Stack storage.
  return_stack_store store_inst (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .port(stk.store)
  );

  // ==========================================================================
  // Datapath.
  always_comb begin
    rot_left = {i_mem_rdata[exec_pkg::MSB-1:exec_pkg::LSB], i_mem_rdata[exec_pkg::MSB]};
    rot_left_carry = {i_mem_rdata[exec_pkg::MSB-1:exec_pkg::LSB], i_carry};
    rot_right = {i_mem_rdata[exec_pkg::LSB], i_mem_rdata[exec_pkg::MSB:exec_pkg::LSB+1]};
    rot_right_carry = {i_carry, i_mem_rdata[exec_pkg::MSB:exec_pkg::LSB+1]};
    decremented = i_mem_rdata - exec_pkg::BYTE_ONE;
    difference = {1'b0, i_acc} + {1'b0, ~i_mem_rdata} + {{exec_pkg::DATA_W{1'b0}}, i_carry};
    low_difference = {1'b0, i_acc[exec_pkg::NIBBLE_W-1:0]}
                   + {1'b0, ~i_mem_rdata[exec_pkg::NIBBLE_W-1:0]}
                   + {{exec_pkg::NIBBLE_W{1'b0}}, i_carry};
    sub_overflow = (i_acc[exec_pkg::MSB] != i_mem_rdata[exec_pkg::MSB])
                 && (difference[exec_pkg::MSB] != i_acc[exec_pkg::MSB]);
  end

  // ==========================================================================
  // Stack access.
  always_comb begin
    return_issue = 1'b0;
    if (r.state == exec_pkg::st_idle && i_op_valid) begin
      case (i_op)
        exec_pkg::subroutine_return_op,
        exec_pkg::return_with_immediate_op,
        exec_pkg::interrupt_return_op: begin
          return_issue = 1'b1;
        end
        default: begin
          return_issue = 1'b0;
        end
      endcase
    end
    push_taken = i_push && !return_issue;
    stk.read_en = return_issue;
    stk.write_en = push_taken;
    stk.wdata = i_push_pc;
    if (return_issue) begin
      stk.addr = r.sp - exec_pkg::SP_STEP;
    end else begin
      stk.addr = r.sp;
    end
  end

  // ==========================================================================
  // Sequencing.
  always_comb begin
    next_r = r;
    next_r.pc_load = 1'b0;
    next_r.acc_we = 1'b0;
    next_r.mem_we = 1'b0;
    next_r.carry_we = 1'b0;
    next_r.arith_we = 1'b0;
    next_r.skip = 1'b0;
    next_r.done = 1'b0;
    if (i_interrupt_taken) begin
      next_r.gie = 1'b0;
    end
    if (push_taken) begin
      next_r.sp = r.sp + exec_pkg::SP_STEP;
    end
    case (r.state)
      exec_pkg::st_idle: begin
        if (i_op_valid) begin
          next_r.pend_op = i_op;
          next_r.imm = i_imm;
          next_r.done = 1'b1;
          case (i_op)
            exec_pkg::subroutine_return_op,
            exec_pkg::return_with_immediate_op,
            exec_pkg::interrupt_return_op: begin
              next_r.sp = r.sp - exec_pkg::SP_STEP;
              next_r.done = 1'b0;
              next_r.state = exec_pkg::st_return;
            end
            exec_pkg::rotate_left_mem_op: begin
              next_r.mem_wdata = rot_left;
              next_r.mem_we = 1'b1;
            end
            exec_pkg::rotate_left_to_acc_op: begin
              next_r.acc = rot_left;
              next_r.acc_we = 1'b1;
            end
            exec_pkg::rotate_left_carry_mem_op: begin
              next_r.mem_wdata = rot_left_carry;
              next_r.mem_we = 1'b1;
              next_r.carry = i_mem_rdata[exec_pkg::MSB];
              next_r.carry_we = 1'b1;
            end
            exec_pkg::rotate_left_carry_to_acc_op: begin
              next_r.acc = rot_left_carry;
              next_r.acc_we = 1'b1;
              next_r.carry = i_mem_rdata[exec_pkg::MSB];
              next_r.carry_we = 1'b1;
            end
            exec_pkg::rotate_right_mem_op: begin
              next_r.mem_wdata = rot_right;
              next_r.mem_we = 1'b1;
            end
            exec_pkg::rotate_right_to_acc_op: begin
              next_r.acc = rot_right;
              next_r.acc_we = 1'b1;
            end
            exec_pkg::rotate_right_carry_mem_op: begin
              next_r.mem_wdata = rot_right_carry;
              next_r.mem_we = 1'b1;
              next_r.carry = i_mem_rdata[exec_pkg::LSB];
              next_r.carry_we = 1'b1;
            end
            exec_pkg::rotate_right_carry_to_acc_op: begin
              next_r.acc = rot_right_carry;
              next_r.acc_we = 1'b1;
              next_r.carry = i_mem_rdata[exec_pkg::LSB];
              next_r.carry_we = 1'b1;
            end
            exec_pkg::subtract_borrow_to_acc_op,
            exec_pkg::subtract_borrow_to_mem_op: begin
              next_r.carry = difference[exec_pkg::DATA_W];
              next_r.aux_carry = low_difference[exec_pkg::NIBBLE_W];
              next_r.overflow = sub_overflow;
              next_r.zero = (difference[exec_pkg::MSB:0] == exec_pkg::BYTE_RESET);
              next_r.carry_we = 1'b1;
              next_r.arith_we = 1'b1;
              if (i_op == exec_pkg::subtract_borrow_to_acc_op) begin
                next_r.acc = difference[exec_pkg::MSB:0];
                next_r.acc_we = 1'b1;
              end else begin
                next_r.mem_wdata = difference[exec_pkg::MSB:0];
                next_r.mem_we = 1'b1;
              end
            end
            exec_pkg::decrement_skip_zero_op,
            exec_pkg::decrement_skip_zero_to_acc_op: begin
              if (i_op == exec_pkg::decrement_skip_zero_op) begin
                next_r.mem_wdata = decremented;
                next_r.mem_we = 1'b1;
              end else begin
                next_r.acc = decremented;
                next_r.acc_we = 1'b1;
              end
              if (decremented == exec_pkg::BYTE_RESET) begin
                next_r.skip = 1'b1;
                next_r.done = 1'b0;
                next_r.state = exec_pkg::st_dummy;
              end
            end
            default: begin
              next_r.done = 1'b0;
            end
          endcase
        end
      end
      exec_pkg::st_return: begin
        next_r.pc = stk.rdata;
        next_r.pc_load = 1'b1;
        next_r.done = 1'b1;
        next_r.state = exec_pkg::st_idle;
        if (r.pend_op == exec_pkg::return_with_immediate_op) begin
          next_r.acc = r.imm;
          next_r.acc_we = 1'b1;
        end
        if (r.pend_op == exec_pkg::interrupt_return_op) begin
          next_r.gie = 1'b1;
        end
      end
      exec_pkg::st_dummy: begin
        next_r.done = 1'b1;
        next_r.state = exec_pkg::st_idle;
      end
      default: begin
        next_r.state = exec_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r.state <= exec_pkg::st_idle;
      r.pend_op <= exec_pkg::no_op;
      r.imm <= exec_pkg::BYTE_RESET;
      r.sp <= exec_pkg::SP_RESET;
      r.pc <= exec_pkg::PC_RESET;
      r.pc_load <= 1'b0;
      r.acc <= exec_pkg::BYTE_RESET;
      r.acc_we <= 1'b0;
      r.mem_wdata <= exec_pkg::BYTE_RESET;
      r.mem_we <= 1'b0;
      r.carry <= 1'b0;
      r.carry_we <= 1'b0;
      r.overflow <= 1'b0;
      r.zero <= 1'b0;
      r.aux_carry <= 1'b0;
      r.arith_we <= 1'b0;
      r.gie <= exec_pkg::GIE_RESET;
      r.skip <= 1'b0;
      r.done <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs.
  assign o_busy = (r.state != exec_pkg::st_idle);
  assign o_done = r.done;
  assign o_skip = r.skip;
  assign o_pc_load = r.pc_load;
  assign o_pc = r.pc;
  assign o_acc_we = r.acc_we;
  assign o_acc_wdata = r.acc;
  assign o_mem_we = r.mem_we;
  assign o_mem_wdata = r.mem_wdata;
  assign o_carry_we = r.carry_we;
  assign o_carry = r.carry;
  assign o_arith_flags_we = r.arith_we;
  assign o_overflow = r.overflow;
  assign o_zero = r.zero;
  assign o_aux_carry = r.aux_carry;
  assign o_global_interrupt_enable = r.gie;
  assign o_stack_pointer = r.sp;

endmodule

/* return_stack_store.sv */
`timescale 1ns/1ps

// ============================================================================
// Return address storage with registered read data.
module return_stack_store (
  input wire logic i_clock,
  input wire logic i_reset_n,
  stack_if.store port
);

  typedef struct packed {
    logic [exec_pkg::PC_W-1:0] rdata;
  } store_reg_t;

  logic [exec_pkg::PC_W-1:0] mem [exec_pkg::STACK_DEPTH];
  store_reg_t r;
  store_reg_t next_r;

  // ==========================================================================
  // Storage array.
  always_ff @(posedge i_clock) begin
    if (port.write_en) begin
      mem[port.addr] <= port.wdata;
    end
  end

  // ==========================================================================
  // Read register.
  always_comb begin
    next_r = r;
    if (port.read_en) begin
      next_r.rdata = mem[port.addr];
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign port.rdata = r.rdata;

endmodule

/* stack_if.sv */
`timescale 1ns/1ps

// ============================================================================
// Return stack access between the sequencer and its storage.
interface stack_if;
  logic write_en;
  logic read_en;
  logic [exec_pkg::SP_W-1:0] addr;
  logic [exec_pkg::PC_W-1:0] wdata;
  logic [exec_pkg::PC_W-1:0] rdata;

  modport owner(
    output write_en,
    output read_en,
    output addr,
    output wdata,
    input rdata
  );

  modport store(
    input write_en,
    input read_en,
    input addr,
    input wdata,
    output rdata
  );
endinterface

/* tb.sv */
`timescale 1ns/1ps

// ============================================================================
// Stimulus and comparisons.
module tb;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_op_valid = 1'b0;
  exec_pkg::op_t i_op = exec_pkg::no_op;
  logic [7:0] i_imm = 8'h00;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [7:0] i_acc = 8'h00;
  logic i_carry = 1'b0;
  logic i_push = 1'b0;
  logic [11:0] i_push_pc = 12'h000;
  logic i_interrupt_taken = 1'b0;
  logic o_busy, o_done, o_skip, o_pc_load, o_acc_we, o_mem_we, o_carry_we, o_carry;
  logic o_arith_flags_we, o_overflow, o_zero, o_aux_carry, o_global_interrupt_enable;
  logic [11:0] o_pc;
  logic [7:0] o_acc_wdata, o_mem_wdata;
  logic [2:0] o_stack_pointer;
  int num_errors = 0;
  int checks_done = 0;
  always #4 i_clock = ~i_clock;
  return_rotate_skip_exec return_rotate_skip_exec_i (.*);

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask
  task automatic issue(input exec_pkg::op_t op, input logic [7:0] m, input logic c);
    i_op_valid = 1'b1;
    i_op = op;
    i_mem_rdata = m;
    i_carry = c;
    tick();
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic rotate_all();
    logic [2:0] n;
    logic [7:0] m;
    logic [7:0] b;
    logic c;
    m = 8'h96;
    for (int k = 0; k < 16; k++) begin
      n = k[3:1];
      c = k[0];
      issue(exec_pkg::op_t'(4 + k / 2), m, c);
      b = n[2] ? {(n[1] ? c : m[0]), m[7:1]} : {m[6:0], (n[1] ? c : m[7])};
      check("acc_we", o_acc_we, n[0]);
      check("mem_we", o_mem_we, !n[0]);
      check("rot", n[0] ? o_acc_wdata : o_mem_wdata, b);
      check("carry_we", o_carry_we, n[1]);
      if (n[1]) check("carry", o_carry, n[2] ? m[0] : m[7]);
      check("done", o_done, 1'b1);
    end
    issue(exec_pkg::no_op, m, 1'b0);
    check("no_op", {o_done, o_busy, o_acc_we, o_mem_we, o_carry_we}, 5'h00);
  endtask
  task automatic subtract();
    logic [7:0] av [4] = '{8'h10, 8'h80, 8'h05, 8'h00};
    logic [7:0] mv [4] = '{8'h01, 8'h01, 8'h04, 8'h00};
    logic [8:0] s;
    logic [4:0] h;
    logic c;
    for (int k = 0; k < 4; k++) begin
      c = k[1];
      i_acc = av[k];
      s = {1'b0, av[k]} + {1'b0, ~mv[k]} + 9'(c);
      h = {1'b0, av[k][3:0]} + {1'b0, ~mv[k][3:0]} + 5'(c);
      issue(k[0] ? exec_pkg::subtract_borrow_to_mem_op : exec_pkg::subtract_borrow_to_acc_op,
        mv[k], c);
      check("sub we", {o_mem_we, o_acc_we, o_arith_flags_we}, {k[0], !k[0], 1'b1});
      check("sub", k[0] ? o_mem_wdata : o_acc_wdata, s[7:0]);
      check("c", o_carry, s[8]);
      check("ac", o_aux_carry, h[4]);
      check("z", o_zero, s[7:0] == 8'h00);
      check("ov", o_overflow, (av[k][7] == ~mv[k][7]) && (s[7] != av[k][7]));
    end
  endtask
  task automatic decrement();
    logic [7:0] m;
    for (int k = 0; k < 4; k++) begin
      m = k[0] ? 8'h05 : 8'h01;
      issue(k[1] ? exec_pkg::decrement_skip_zero_to_acc_op : exec_pkg::decrement_skip_zero_op,
        m, 1'b0);
      check("dec we", {o_acc_we, o_mem_we, o_arith_flags_we}, {k[1], !k[1], 1'b0});
      check("dec", k[1] ? o_acc_wdata : o_mem_wdata, m - 8'h01);
      check("skip", {o_skip, o_busy, o_done}, {!k[0], !k[0], k[0]});
      if (!k[0]) begin
        i_op = exec_pkg::rotate_left_mem_op;
        tick();
        i_op_valid = 1'b0;
        check("dummy", {o_done, o_busy, o_skip, o_mem_we}, 4'b1000);
        tick();
        check("refused", o_mem_we, 1'b0);
      end
    end
  endtask
  task automatic returns();
    logic [11:0] pcs [3] = '{12'h123, 12'h456, 12'h789};
    exec_pkg::op_t ops [3] = '{exec_pkg::interrupt_return_op,
      exec_pkg::return_with_immediate_op, exec_pkg::subroutine_return_op};
    i_op_valid = 1'b0;
    for (int k = 0; k < 3; k++) begin
      i_push = 1'b1;
      i_push_pc = pcs[k];
      tick();
    end
    i_push = 1'b0;
    check("sp", o_stack_pointer, 3'h3);
    i_imm = 8'h5a;
    for (int k = 0; k < 3; k++) begin
      issue(ops[k], 8'h00, 1'b0);
      check("ret busy", {o_busy, o_stack_pointer}, {1'b1, 3'(2 - k)});
      if (k == 0) i_interrupt_taken = 1'b1;
      tick();
      if (k == 0) i_interrupt_taken = 1'b0;
      check("ret", {o_pc_load, o_done, o_pc}, {2'b11, pcs[2 - k]});
      if (k == 0) check("gie", o_global_interrupt_enable, 1'b1);
      if (k == 1) check("imm", {o_acc_we, o_acc_wdata}, 9'h15a);
    end
    i_op_valid = 1'b0;
    i_interrupt_taken = 1'b1;
    tick();
    i_interrupt_taken = 1'b0;
    check("gie off", o_global_interrupt_enable, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    #1;
    i_reset_n = 1'b1;
    check("reset", {o_busy, o_done, o_stack_pointer, o_global_interrupt_enable}, 6'h00);
    rotate_all();
    subtract();
    decrement();
    returns();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    num_errors++;
    give_verdict();
  end
endmodule

bind return_rotate_skip_exec exec_properties exec_properties_i (.*);
